// ===== swbr_host.sv
// Host controller model that drives the register strobe port.
`timescale 1ns/100ps
module swbr_host (
   input  wire logic           sys_clk,
   output swbr_pkg::swbr_req_t req
);
   logic [7:0] expQ [$];
   initial req = '0;
   // ==========================================
   // Strobe cycles
   // Idle address and data are inverted so that stale values never look valid.
   task automatic write(input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= {2'b10, a, d};
      @(posedge sys_clk);
      req <= {2'b00, ~a, ~d};
   endtask
   task automatic read(input logic [6:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      req <= {2'b01, a, ~req.data};
      expQ.push_back(e);
      @(posedge sys_clk);
      req <= {2'b00, ~a, ~req.data};
   endtask
   task automatic writeDog(input logic [6:0] low);
      write(swbr_pkg::ADDR_WD, {^low, low});
   endtask
endmodule

// ===== swbr_pkg.sv
// Package for the watchdog, bus and wake control register bank.
package swbr_pkg;

   // ==========================================================
   // Register addresses on the serial control port
   localparam logic [6:0] ADDR_WD   = 7'h03;
   localparam logic [6:0] ADDR_BUS  = 7'h04;
   localparam logic [6:0] ADDR_IWK  = 7'h06;
   localparam logic [6:0] ADDR_EWK  = 7'h07;

   // ==========================================================
   // Field positions
   localparam int WD_PAR_BIT    = 7;
   localparam int WD_STOPLO_BIT = 6;
   localparam int DOG_TYPE_SELECT_BIT    = 5;
   localparam int WD_BUSWK_BIT  = 4;
   localparam int IWK_TMR_BIT   = 6;
   localparam int IWK_STOPHI_BIT = 2;
   localparam int EWK_GLOB_BIT  = 7;
   localparam int EWK_SENSE_BIT = 5;
   localparam int EWK_EN_BIT    = 0;

   // Writable bits of each register; all others are reserved.
   localparam logic [7:0] WD_MASK  = 8'hF7;
   localparam logic [7:0] BUS_MASK = 8'h03;
   localparam logic [7:0] IWK_MASK = 8'h44;
   localparam logic [7:0] EWK_MASK = 8'hA1;

   // ==========================================================
   // Reset, restart and fail-safe values
   localparam logic [7:0] WD_RST       = 8'h14;
   localparam logic [7:0] WD_RESTART   = 8'h04;
   localparam logic [7:0] WD_KEEP      = 8'hB0;
   localparam logic [7:0] BUS_RST      = 8'h00;
   localparam logic [7:0] BUS_RST_DEV  = 8'h03;
   localparam logic [7:0] BUS_FAILSAFE = 8'h01;
   localparam logic [7:0] IWK_RST      = 8'h00;
   localparam logic [7:0] IWK_KEEP     = 8'h40;
   localparam logic [7:0] EWK_RST      = 8'h01;
   localparam logic [7:0] EWK_KEEP     = 8'hA1;
   localparam logic [7:0] EWK_FAILSAFE = 8'h01;
   localparam logic [7:0] EWK_FS_KEEP  = 8'hA0;

   // ==========================================================
   // Transceiver modes
   localparam logic [1:0] CAN_OFF    = 2'h0;
   localparam logic [1:0] CAN_WAKE   = 2'h1;
   localparam logic [1:0] CAN_RXONLY = 2'h2;
   localparam logic [1:0] CAN_NORMAL = 2'h3;

   // Watchdog periods in milliseconds, indexed by the period code.
   localparam logic [13:0] PERIOD_MS [0:7] = '{14'h000A, 14'h0014, 14'h0032, 14'h0064,
                                               14'h00C8, 14'h01F4, 14'h03E8, 14'h2710};

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] data;
   } swbr_req_t;

   typedef struct packed {
      logic       softRst;
      logic       restart;
      logic [1:0] restartCan;
      logic       failSafe;
      logic       stopToNormal;
   } swbr_evt_t;

endpackage

// ===== swbr_regs.sv
// Watchdog, bus transceiver and wake control registers with their side effects.
//
// Behaviour
// - Watchdog byte checked for even parity
// - Bit 6 requests watchdog off in Stop
// - Bit 5 selects window or time-out watchdog
// - Bit 4 starts watchdog on bus wake
// - Period code selects 10 ms to 10 s
// - Reserved bits ignore writes, read zero
// - Watchdog reset 0x14, restart keeps 7,5,4
// - Fail-safe forces bus register to 0x01
// - Development mode resets bus mode normal
// - Restart bus mode follows cause, upper zero
// - Bit 6 enables cyclic timer wake
// - Stop to Normal clears second stop bit
// - Global bit routes all status to interrupt
// - Sense select suppresses input wake events
// - External wake reset 0x01, restart keeps 7,5,0
// - Bit 0 enables high-voltage input wake
`timescale 1ns/100ps
module swbr_regs (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire swbr_pkg::swbr_req_t req,
   input  wire swbr_pkg::swbr_evt_t evt,
   input  wire logic               devMode,
   input  wire logic               inStopMode,
   input  wire logic               busWakeInStop,
   input  wire logic               hvWakeInput,
   input  wire logic               timerWakeEvent,
   input  wire logic               statusEvent,
   output logic [7:0]              rdData,
   output logic                    parityOk,
   output logic                    dogWindowMode,
   output logic [13:0]             dogPeriodMs,
   output logic                    stopDogOff,
   output logic                    dogStartLongWin,
   output logic [1:0]              canMode,
   output logic                    timerWakeEn,
   output logic                    hvWakeEn,
   output logic                    hvSenseSel,
   output logic                    irqOutN
);

   // ==========================================================
   // Register storage
   logic [7:0]  wdCfg_r;
   logic [7:0]  busCfg_r;
   logic [7:0]  iwkCfg_r;
   logic [7:0]  ewkCfg_r;
   logic [7:0]  rdData_r;
   logic        parityOk_r;
   logic        stopDogOff_r;
   logic        dogStart_r;
   logic [13:0] periodMs_r;
   logic        irqN_r;
   logic        wakeAny;

   function automatic logic hit(input swbr_pkg::swbr_req_t r, input logic [6:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   // Soft reset behaves like power-on reset for this bank.
   logic initAll;
   assign initAll = rst || evt.softRst;

   // ==========================================================
   // Watchdog configuration
   // reset and restart values
   always_ff @(posedge sys_clk) begin
      if (initAll) begin
         wdCfg_r <= swbr_pkg::WD_RST;
      end else if (evt.restart) begin
         wdCfg_r <= (wdCfg_r & swbr_pkg::WD_KEEP) | swbr_pkg::WD_RESTART;
      end else if (hit(req, swbr_pkg::ADDR_WD)) begin
         wdCfg_r <= req.data & swbr_pkg::WD_MASK;
      end
   end

   // even parity checked on the written byte
   always_ff @(posedge sys_clk) begin
      if (initAll) begin
         parityOk_r <= 1'b1;
      end else if (hit(req, swbr_pkg::ADDR_WD)) begin
         parityOk_r <= ~^req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Reset shows the period of the reset code, so the counter never starts on a stale value.
         periodMs_r <= swbr_pkg::PERIOD_MS[swbr_pkg::WD_RST[2:0]];
      end else begin
         periodMs_r <= swbr_pkg::PERIOD_MS[wdCfg_r[2:0]];
      end
   end

   // ==========================================================
   // Bus transceiver mode
   always_ff @(posedge sys_clk) begin
      if (initAll) begin
         busCfg_r <= devMode ? swbr_pkg::BUS_RST_DEV : swbr_pkg::BUS_RST;
      end else if (evt.failSafe) begin
         busCfg_r <= swbr_pkg::BUS_FAILSAFE;
      end else if (evt.restart) begin
         busCfg_r <= {6'h00, evt.restartCan};
      end else if (hit(req, swbr_pkg::ADDR_BUS)) begin
         busCfg_r <= req.data & swbr_pkg::BUS_MASK;
      end
   end

   // ==========================================================
   // Internal wake control
   // A hardware clear on leaving Stop wins over a write in the same cycle,
   // so software cannot re-arm the bit while the mode change is in flight.
   always_ff @(posedge sys_clk) begin
      if (initAll) begin
         iwkCfg_r <= swbr_pkg::IWK_RST;
      end else if (evt.restart) begin
         iwkCfg_r <= iwkCfg_r & swbr_pkg::IWK_KEEP;
      end else if (evt.stopToNormal) begin
         iwkCfg_r[swbr_pkg::IWK_STOPHI_BIT] <= 1'b0;
      end else if (hit(req, swbr_pkg::ADDR_IWK)) begin
         iwkCfg_r <= req.data & swbr_pkg::IWK_MASK;
      end
   end

   // ==========================================================
   // External wake control
   always_ff @(posedge sys_clk) begin
      if (initAll) begin
         ewkCfg_r <= swbr_pkg::EWK_RST;
      end else if (evt.failSafe) begin
         if (!ewkCfg_r[swbr_pkg::EWK_SENSE_BIT]) begin
            ewkCfg_r <= (ewkCfg_r & swbr_pkg::EWK_FS_KEEP) | swbr_pkg::EWK_FAILSAFE;
         end
      end else if (evt.restart) begin
         // restart keeps routing, sense and enable
         ewkCfg_r <= ewkCfg_r & swbr_pkg::EWK_KEEP;
      end else if (hit(req, swbr_pkg::ADDR_EWK)) begin
         ewkCfg_r <= req.data & swbr_pkg::EWK_MASK;
      end
   end

   // ==========================================================
   // Read path
   // unmapped and reserved read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_r <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            swbr_pkg::ADDR_WD:  rdData_r <= wdCfg_r;
            swbr_pkg::ADDR_BUS: rdData_r <= busCfg_r;
            swbr_pkg::ADDR_IWK: rdData_r <= iwkCfg_r;
            swbr_pkg::ADDR_EWK: rdData_r <= ewkCfg_r;
            default:            rdData_r <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Watchdog controls toward the counter
   // low stop bit
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stopDogOff_r <= 1'b0;
      end else begin
         stopDogOff_r <= inStopMode && wdCfg_r[swbr_pkg::WD_STOPLO_BIT]
                         && iwkCfg_r[swbr_pkg::IWK_STOPHI_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dogStart_r <= 1'b0;
      end else begin
         dogStart_r <= busWakeInStop && wdCfg_r[swbr_pkg::WD_BUSWK_BIT];
      end
   end

   // ==========================================================
   // Wake qualification and interrupt routing
   // sense mode suppresses input wake
   assign wakeAny = (hvWakeInput && ewkCfg_r[swbr_pkg::EWK_EN_BIT] && !ewkCfg_r[swbr_pkg::EWK_SENSE_BIT])
                    || (timerWakeEvent && iwkCfg_r[swbr_pkg::IWK_TMR_BIT])
                    || (busWakeInStop && busCfg_r[1:0] == swbr_pkg::CAN_WAKE);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqN_r <= 1'b1;
      end else begin
         irqN_r <= !(wakeAny || (statusEvent && ewkCfg_r[swbr_pkg::EWK_GLOB_BIT]));
      end
   end

   // ==========================================================
   // Outputs
   assign rdData          = rdData_r;
   assign parityOk        = parityOk_r;
   assign dogWindowMode   = wdCfg_r[swbr_pkg::DOG_TYPE_SELECT_BIT];
   assign dogPeriodMs     = periodMs_r;
   assign stopDogOff      = stopDogOff_r;
   assign dogStartLongWin = dogStart_r;
   assign canMode         = busCfg_r[1:0];
   assign timerWakeEn     = iwkCfg_r[swbr_pkg::IWK_TMR_BIT];
   assign hvWakeEn        = ewkCfg_r[swbr_pkg::EWK_EN_BIT];
   assign hvSenseSel      = ewkCfg_r[swbr_pkg::EWK_SENSE_BIT];
   assign irqOutN         = irqN_r;

   // ==========================================================
   // Checks
   AST_PARITY: assert property (@(posedge sys_clk) disable iff (rst)
      hit(req, swbr_pkg::ADDR_WD) && !evt.softRst |=> parityOk == ~^$past(req.data))
      else $error("parity flag does not follow written byte");

   AST_STOP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      stopDogOff |-> $past(inStopMode) && $past(wdCfg_r[6]) && $past(iwkCfg_r[2]))
      else $error("watchdog off in Stop without both bits");

   AST_WIN_SEL: assert property (@(posedge sys_clk) disable iff (rst)
      hit(req, swbr_pkg::ADDR_WD) && !evt.softRst && !evt.restart |=> dogWindowMode == $past(req.data[5]))
      else $error("watchdog type not taken from write");

   AST_BUS_START: assert property (@(posedge sys_clk) disable iff (rst)
      busWakeInStop && wdCfg_r[4] |=> dogStartLongWin)
      else $error("watchdog not started on bus wake");

   AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
      (wdCfg_r[3] == 1'b0) && (busCfg_r[7:2] == 6'h00) && ((iwkCfg_r & 8'hBB) == 8'h00) && ((ewkCfg_r & 8'h5E) == 8'h00))
      else $error("reserved bit set");

   AST_WD_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
      evt.restart && !evt.softRst |=> wdCfg_r == (($past(wdCfg_r) & 8'hB0) | 8'h04))
      else $error("watchdog restart value wrong");

   AST_FAILSAFE: assert property (@(posedge sys_clk) disable iff (rst)
      evt.failSafe && !evt.softRst |=> busCfg_r == 8'h01 ##1 canMode == 2'h1 || $past(evt.restart) || $past(req.wr))
      else $error("fail-safe did not make bus wake capable");

   AST_DEV_RESET: assert property (@(posedge sys_clk) disable iff (rst)
      evt.softRst && devMode |=> canMode == 2'h3)
      else $error("development mode default not normal");

   AST_STOP_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
      evt.stopToNormal |=> !iwkCfg_r[2])
      else $error("second stop bit not cleared");

   AST_EWK_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
      evt.restart && !evt.softRst && !evt.failSafe |=> ewkCfg_r == ($past(ewkCfg_r) & 8'hA1))
      else $error("external wake restart value wrong");

   AST_IRQ_ROUTE: assert property (@(posedge sys_clk) disable iff (rst)
      statusEvent && !wakeAny && !ewkCfg_r[7] |=> irqOutN)
      else $error("status event reached interrupt while routing is local");

   AST_STOP_LO: assert property (@(posedge sys_clk) disable iff (rst)
      inStopMode && !wdCfg_r[swbr_pkg::WD_STOPLO_BIT] |=> !stopDogOff)
      else $error("watchdog off in Stop with low stop bit clear");

   AST_PERIOD_MIN: assert property (@(posedge sys_clk) disable iff (rst)
      wdCfg_r[2:0] == 3'h0 |=> dogPeriodMs == 14'h000A)
      else $error("period code 0 does not give 10 ms");

   AST_PERIOD_MID: assert property (@(posedge sys_clk) disable iff (rst)
      wdCfg_r[2:0] == 3'h4 |=> dogPeriodMs == 14'h00C8)
      else $error("period code 4 does not give 200 ms");

   AST_PERIOD_MAX: assert property (@(posedge sys_clk) disable iff (rst)
      wdCfg_r[2:0] == 3'h7 |=> dogPeriodMs == 14'h2710)
      else $error("period code 7 does not give 10000 ms");

   AST_CAN_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
      hit(req, swbr_pkg::ADDR_BUS) && !evt.softRst && !evt.failSafe && !evt.restart
      |=> canMode == $past(req.data[1:0]))
      else $error("transceiver mode not taken from write");

   AST_RESTART_CAN: assert property (@(posedge sys_clk) disable iff (rst)
      evt.restart && !evt.softRst && !evt.failSafe
      |=> canMode == $past(evt.restartCan) && busCfg_r[7:2] == 6'h00)
      else $error("restart transceiver mode does not follow cause");

   AST_TIMER_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
      hit(req, swbr_pkg::ADDR_IWK) && !evt.softRst && !evt.restart && !evt.stopToNormal
      |=> timerWakeEn == $past(req.data[6]))
      else $error("timer wake enable not taken from write");

   AST_TIMER_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
      timerWakeEvent && timerWakeEn |=> !irqOutN)
      else $error("enabled timer wake did not reach interrupt");

   AST_SENSE_MUTE: assert property (@(posedge sys_clk) disable iff (rst)
      hvWakeInput && hvSenseSel && !timerWakeEvent && !busWakeInStop && !statusEvent |=> irqOutN)
      else $error("input wake reached interrupt in sense mode");

   AST_HV_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
      hvWakeInput && hvWakeEn && !hvSenseSel |=> !irqOutN)
      else $error("enabled input wake did not reach interrupt");

   AST_HV_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      hvWakeInput && !hvWakeEn && !timerWakeEvent && !busWakeInStop && !statusEvent |=> irqOutN)
      else $error("disabled input wake reached interrupt");

   AST_IRQ_GLOBAL: assert property (@(posedge sys_clk) disable iff (rst)
      statusEvent && ewkCfg_r[swbr_pkg::EWK_GLOB_BIT] |=> !irqOutN)
      else $error("status event missed interrupt with global routing");

   AST_IRQ_ONE: assert property (@(posedge sys_clk) disable iff (rst)
      !irqOutN && !wakeAny && !statusEvent |=> irqOutN)
      else $error("interrupt held low without a new event");

   AST_READ_UNMAPPED: assert property (@(posedge sys_clk) disable iff (rst)
      req.rd && req.addr != swbr_pkg::ADDR_WD && req.addr != swbr_pkg::ADDR_BUS
      && req.addr != swbr_pkg::ADDR_IWK && req.addr != swbr_pkg::ADDR_EWK |=> rdData == 8'h00)
      else $error("unmapped read not zero");

   AST_READ_BUS: assert property (@(posedge sys_clk) disable iff (rst)
      req.rd && req.addr == swbr_pkg::ADDR_BUS |=> rdData[7:2] == 6'h00)
      else $error("reserved transceiver bits read nonzero");

   AST_WD_RESET: assert property (@(posedge sys_clk) disable iff (rst)
      evt.softRst |=> wdCfg_r == swbr_pkg::WD_RST)
      else $error("watchdog soft reset value wrong");

   AST_EWK_RESET: assert property (@(posedge sys_clk) disable iff (rst)
      evt.softRst |=> ewkCfg_r == swbr_pkg::EWK_RST)
      else $error("external wake soft reset value wrong");

   AST_FS_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
      evt.failSafe && !evt.softRst && !hvSenseSel |=> hvWakeEn)
      else $error("fail-safe left input wake disabled");

   AST_DEV_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      evt.softRst && !devMode |=> canMode == swbr_pkg::CAN_OFF)
      else $error("soft reset outside development mode not off");

endmodule

// ===== swbr_regs_test.sv
// Self-checking testbench for the watchdog, bus and wake register bank.
`timescale 1ns/100ps
module swbr_regs_test;
   logic                sys_clk, rst, devMode, inStopMode;
   logic                rdSeen = 1'b0;
   logic [7:0]          ev, rdData, d;
   logic [1:0]          canCause, canMode;
   logic                parityOk, dogWindowMode, stopDogOff, dogStartLongWin;
   logic                timerWakeEn, hvWakeEn, hvSenseSel, irqOutN;
   logic [13:0]         dogPeriodMs;
   swbr_pkg::swbr_req_t req;
   swbr_pkg::swbr_evt_t evt;
   int                  errorCnt, comparisons, k;
   int                  cycles = 0;
   logic [6:0]          adr [0:4] = '{7'h03, 7'h04, 7'h06, 7'h07, 7'h05};
   logic [7:0]          rv [0:4] = '{8'h14, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0]          msk [0:4] = '{8'hF7, 8'h03, 8'h44, 8'hA1, 8'h00};
   logic [13:0]         per [0:7] = '{14'h000A, 14'h0014, 14'h0032, 14'h0064,
                                      14'h00C8, 14'h01F4, 14'h03E8, 14'h2710};
   logic [7:0]          ewkT [0:6] = '{8'h01, 8'h21, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
   int                  evT [0:6] = '{5, 5, 5, 7, 7, 6, 4};
   logic                irqT [0:6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

   // Strobe order: soft reset, restart, fail-safe, stop to normal, bus wake, input wake, timer, status.
   assign evt = {ev[0], ev[1], canCause, ev[2], ev[3]};

   swbr_regs u_swbr_regs (
      .sys_clk(sys_clk), .rst(rst), .req(req), .evt(evt), .devMode(devMode),
      .inStopMode(inStopMode), .busWakeInStop(ev[4]), .hvWakeInput(ev[5]),
      .timerWakeEvent(ev[6]), .statusEvent(ev[7]), .rdData(rdData), .parityOk(parityOk),
      .dogWindowMode(dogWindowMode), .dogPeriodMs(dogPeriodMs), .stopDogOff(stopDogOff),
      .dogStartLongWin(dogStartLongWin), .canMode(canMode), .timerWakeEn(timerWakeEn),
      .hvWakeEn(hvWakeEn), .hvSenseSel(hvSenseSel), .irqOutN(irqOutN)
   );
   swbr_host u_swbr_host (
      .sys_clk(sys_clk),
      .req(req)
   );

   // ==========================================
   // Clock, read monitor and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      rdSeen <= req.rd;
      cycles <= cycles + 1;
      if (rdSeen) check("rdData", {6'h00, rdData}, {6'h00, u_swbr_host.expQ.pop_front()});
      if (cycles == 5000) begin
         errorCnt++;
         summarize();
      end
   end

   // ==========================================
   // Helpers
   task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic chk1(input string name, input logic seen, input logic exp);
      check(name, {13'h0000, seen}, {13'h0000, exp});
   endtask
   task automatic W(input int i, input logic [7:0] v);
      u_swbr_host.write(adr[i], v);
   endtask
   task automatic R(input int i, input logic [7:0] e);
      u_swbr_host.read(adr[i], e);
   endtask
   task automatic pulse(input int i);
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
      if (errorCnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      rst = 1'b1;
      devMode = 1'b0;
      inStopMode = 1'b0;
      ev = 8'h00;
      canCause = 2'h2;
      errorCnt = 0;
      comparisons = 0;
      k = $urandom(28117);
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk1("parityOk", parityOk, 1'b1);
      for (int i = 0; i < 5; i++) R(i, rv[i]);
      for (int i = 0; i < 5; i++) begin
         W(i, 8'hFF);
         R(i, msk[i]);
      end
      $display("test reset and reserved done");
      for (int i = 0; i < 40; i++) begin
         k = $urandom % 4;
         d = 8'($urandom);
         W(k, d);
         R(k, d & msk[k]);
      end
      for (int m = 0; m < 4; m++) begin
         W(1, 8'(m));
         @(negedge sys_clk);
         check("canMode", {12'h000, canMode}, 14'(m));
      end
      $display("test random access done");
      W(0, 8'hB5);
      @(negedge sys_clk);
      chk1("parityOk", parityOk, 1'b0);
      for (int c = 0; c < 8; c++) begin
         u_swbr_host.writeDog({1'b0, c[0], 2'b00, c[2:0]});
         repeat (2) @(negedge sys_clk);
         check("dogPeriodMs", dogPeriodMs, per[c]);
         chk1("dogWindowMode", dogWindowMode, c[0]);
         chk1("parityOk", parityOk, 1'b1);
      end
      $display("test watchdog fields done");
      u_swbr_host.writeDog(7'h74);
      W(1, 8'h03);
      W(2, 8'h44);
      W(3, 8'hA1);
      canCause <= 2'($urandom);
      pulse(1);
      R(0, 8'h34);
      R(1, {6'h00, canCause});
      R(2, 8'h40);
      R(3, 8'hA1);
      W(3, 8'h80);
      pulse(2);
      R(1, 8'h01);
      R(3, 8'h81);
      W(2, 8'h44);
      pulse(3);
      R(2, 8'h40);
      $display("test restart and fail-safe done");
      @(posedge sys_clk);
      inStopMode <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         u_swbr_host.writeDog({b[0], 6'h00});
         W(2, {5'h00, b[1], 2'b00});
         repeat (2) @(negedge sys_clk);
         chk1("stopDogOff", stopDogOff, b[0] & b[1]);
      end
      @(posedge sys_clk);
      inStopMode <= 1'b0;
      $display("test stop deactivation done");
      u_swbr_host.writeDog(7'h10);
      W(2, 8'h40);
      W(1, 8'h01);
      @(negedge sys_clk);
      chk1("timerWakeEn", timerWakeEn, 1'b1);
      for (int i = 0; i < 7; i++) begin
         W(3, ewkT[i]);
         @(negedge sys_clk);
         chk1("hvWakeEn", hvWakeEn, ewkT[i][0]);
         chk1("hvSenseSel", hvSenseSel, ewkT[i][5]);
         pulse(evT[i]);
         chk1("irqOutN", irqOutN, irqT[i]);
      end
      chk1("dogStartLongWin", dogStartLongWin, 1'b1);
      $display("test interrupt routing done");
      @(posedge sys_clk);
      devMode <= 1'b1;
      pulse(0);
      R(1, 8'h03);
      R(0, 8'h14);
      @(posedge sys_clk);
      devMode <= 1'b0;
      pulse(0);
      R(1, 8'h00);
      repeat (3) @(posedge sys_clk);
      $display("test development reset done");
      summarize();
   end
endmodule
